// ===== design/fifo_core.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Low clear input, sampled through the two-flop synchroniser, resets the core on aclk
// - Reset returns both pointers to location zero
// - Reset drives full and almost-full high
// - Reset drives empty and almost-empty low
// - Reset zeroes the output register
// - Reset restores both offsets to default
// - Nine-bit words in and out
// - Single-enable mode writes when enable low
// - Words stored in order, independent of reads
// - Enable high: nothing stored, input held
// - Dual-enable mode needs both write enables
// - Full flags low and writes are ignored
// - A read while full releases full flag at the next write edge
// - Full flags change only on write edges
// - Both read enables low pops next word
// - Either read enable high holds output
// - Empty flag low once all read
// - A write into empty releases empty flag at the next read edge
// - Reads ignored while empty, state held
// - Empty flags change only on read edges
// - Works with independent or shared clocks
// - Second enable sampled at reset selects mode
// - Almost-full low at offset free or fewer
// - Almost-empty low at offset stored or fewer
// - Output enable high floats the data outputs
module fifo_core
    import fifo_core_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [AXI_AW-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                write_clock,
    input  wire logic                read_clock,
    input  wire logic                clear_bar,
    input  wire logic                write_enable_a_bar,
    input  wire logic                second_enable_or_load,
    input  wire logic                read_enable_a_bar,
    input  wire logic                read_enable_b_bar,
    input  wire logic                output_enable_bar,
    input  wire logic [DATA_W-1:0]   data_in_bus,
    output logic [DATA_W-1:0]        data_out_bus,
    output logic                     data_out_drive_bar,
    output logic                     full_bar,
    output logic                     almost_full_bar,
    output logic                     empty_bar,
    output logic                     almost_empty_bar
);

    // ========================================================
    // Helpers
    function automatic logic [PTR_W-1:0] to_gray(input logic [PTR_W-1:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    function automatic logic [PTR_W-1:0] from_gray(
        input logic [PTR_W-1:0] g
    );
        logic [PTR_W-1:0] b;
        b = '0;
        b[PTR_W-1] = g[PTR_W-1];
        for (int i = PTR_W - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        from_gray = b;
    endfunction

    // ========================================================
    // Pin synchronisers
    // Clocks from the pins are sampled, so each must stay high and low
    // for at least two aclk periods to be seen.
    logic [PIN_W-1:0] pin_s1_q;
    logic [PIN_W-1:0] pin_s2_q;
    logic             wclk_prev_q;
    logic             rclk_prev_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_s1_q <= PIN_RESET;
            pin_s2_q <= PIN_RESET;
        end
        else
        begin
            pin_s1_q <= {data_in_bus, output_enable_bar, read_enable_b_bar,
                         read_enable_a_bar, second_enable_or_load,
                         write_enable_a_bar, clear_bar, read_clock,
                         write_clock};
            pin_s2_q <= pin_s1_q;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wclk_prev_q <= 1'b0;
            rclk_prev_q <= 1'b0;
        end
        else
        begin
            wclk_prev_q <= pin_s2_q[PIN_WCLK];
            rclk_prev_q <= pin_s2_q[PIN_RCLK];
        end
    end

    logic core_rst;
    logic wr_tick;
    logic rd_tick;

    assign core_rst = !aresetn || !pin_s2_q[PIN_CLR];
    // Independent edge detectors keep shared or separate clocks correct
    assign wr_tick = pin_s2_q[PIN_WCLK] && !wclk_prev_q;
    assign rd_tick = pin_s2_q[PIN_RCLK] && !rclk_prev_q;

    // ========================================================
    // Mode strap
    logic dual_q;

    always_ff @(posedge aclk)
    begin
        if (core_rst)
        begin
            dual_q <= pin_s2_q[PIN_WEN2];
        end
    end

    // ========================================================
    // Offset registers
    logic [OFF_W-1:0] empty_off_q;
    logic [OFF_W-1:0] full_off_q;
    logic             reg_wr;
    logic [AXI_AW-1:0] aw_addr_q;
    logic [31:0]      w_data_q;
    logic [3:0]       w_strb_q;

    always_ff @(posedge aclk)
    begin
        if (core_rst)
        begin
            empty_off_q <= OFF_DEFAULT;
            full_off_q  <= OFF_DEFAULT;
        end
        else if (reg_wr && w_strb_q[0])
        begin
            if (aw_addr_q == EMPTY_OFS)
            begin
                empty_off_q <= w_data_q[OFF_W-1:0];
            end
            if (aw_addr_q == FULL_OFS)
            begin
                full_off_q <= w_data_q[OFF_W-1:0];
            end
        end
    end

    // ========================================================
    // Storage and write side
    logic [DATA_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0]  wptr_q;
    logic [PTR_W-1:0]  wgray_q;
    // Read-side Gray pointer, declared here because the write side syncs it
    logic [PTR_W-1:0]  rgray_q;
    logic [PTR_W-1:0]  rgray_w1_q;
    logic [PTR_W-1:0]  rgray_w2_q;
    logic              full_bar_q;
    logic              afull_bar_q;
    logic              wr_ok;
    logic [PTR_W-1:0]  wptr_n;
    logic [PTR_W-1:0]  wcount;
    logic [PTR_W:0]    wfree;

    // Full blocks both enables so unread data is never overwritten
    assign wr_ok = wr_tick && !pin_s2_q[PIN_WENA]
                   && (!dual_q || pin_s2_q[PIN_WEN2])
                   && full_bar_q;
    assign wptr_n = wr_ok ? wptr_q + 1'b1 : wptr_q;
    assign wcount = wptr_n - from_gray(rgray_w2_q);
    assign wfree  = DEPTH_W - {1'b0, wcount};

    always_ff @(posedge aclk)
    begin
        if (wr_ok)
        begin
            mem[wptr_q[ADDR_W-1:0]] <= pin_s2_q[PIN_DATA +: DATA_W];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (core_rst)
        begin
            wptr_q  <= '0;
            wgray_q <= '0;
        end
        else
        begin
            wptr_q  <= wptr_n;
            wgray_q <= to_gray(wptr_n);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (core_rst)
        begin
            rgray_w1_q <= '0;
            rgray_w2_q <= '0;
        end
        else
        begin
            rgray_w1_q <= rgray_q;
            rgray_w2_q <= rgray_w1_q;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (core_rst)
        begin
            full_bar_q  <= 1'b1;
            afull_bar_q <= 1'b1;
        end
        else if (wr_tick)
        begin
            // Pessimistic: a read is seen only after the pointer crosses
            full_bar_q  <= wcount != DEPTH_W[PTR_W-1:0];
            afull_bar_q <= wfree > {1'b0, full_off_q};
        end
    end

    // ========================================================
    // Read side
    logic [PTR_W-1:0]  rptr_q;
    logic [PTR_W-1:0]  wgray_r1_q;
    logic [PTR_W-1:0]  wgray_r2_q;
    logic              empty_bar_q;
    logic              aempty_bar_q;
    logic [DATA_W-1:0] data_out_q;
    logic              rd_ok;
    logic [PTR_W-1:0]  rptr_n;
    logic [PTR_W-1:0]  rcount;

    assign rd_ok = rd_tick && !pin_s2_q[PIN_RENA]
                   && !pin_s2_q[PIN_RENB]
                   && empty_bar_q;
    assign rptr_n = rd_ok ? rptr_q + 1'b1 : rptr_q;
    assign rcount = from_gray(wgray_r2_q) - rptr_n;

    always_ff @(posedge aclk)
    begin
        if (core_rst)
        begin
            wgray_r1_q <= '0;
            wgray_r2_q <= '0;
        end
        else
        begin
            wgray_r1_q <= wgray_q;
            wgray_r2_q <= wgray_r1_q;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (core_rst)
        begin
            rptr_q     <= '0;
            rgray_q    <= '0;
            data_out_q <= '0;
        end
        else
        begin
            rptr_q  <= rptr_n;
            rgray_q <= to_gray(rptr_n);
            if (rd_ok)
            begin
                data_out_q <= mem[rptr_q[ADDR_W-1:0]];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (core_rst)
        begin
            empty_bar_q  <= 1'b0;
            aempty_bar_q <= 1'b0;
        end
        else if (rd_tick)
        begin
            empty_bar_q  <= rcount != '0;
            aempty_bar_q <= {1'b0, rcount} > empty_off_q;
        end
    end

    assign data_out_bus       = data_out_q;
    assign data_out_drive_bar = pin_s2_q[PIN_OE];
    assign full_bar           = full_bar_q;
    assign almost_full_bar    = afull_bar_q;
    assign empty_bar          = empty_bar_q;
    assign almost_empty_bar   = aempty_bar_q;

    // ========================================================
    // AXI4-Lite write channel
    logic aw_hold_q;
    logic w_hold_q;
    logic bvalid_q;
    logic [1:0] bresp_q;

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready  = !w_hold_q && !bvalid_q;
    assign reg_wr        = aw_hold_q && w_hold_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (reg_wr)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (aw_addr_q == EMPTY_OFS || aw_addr_q == FULL_OFS)
                             ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ========================================================
    // AXI4-Lite read channel
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [31:0] status;

    always_comb
    begin
        status = '0;
        status[ST_FULL_BIT]   = full_bar_q;
        status[ST_AFULL_BIT]  = afull_bar_q;
        status[ST_EMPTY_BIT]  = empty_bar_q;
        status[ST_AEMPTY_BIT] = aempty_bar_q;
        status[ST_DUAL_BIT]   = dual_q;
        status[ST_COUNT_LSB +: PTR_W] = wptr_q - from_gray(rgray_w2_q);
    end

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_q)
        begin
            rvalid_q <= 1'b1;
            rresp_q  <= RESP_OKAY;
            unique case (s_axi_araddr)
                STATUS_OFS: rdata_q <= status;
                EMPTY_OFS:  rdata_q <= {24'h00_0000, empty_off_q};
                FULL_OFS:   rdata_q <= {24'h00_0000, full_off_q};
                default:
                begin
                    rdata_q <= '0;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ===== design/fifo_core_pkg.sv
package fifo_core_pkg;

    // ========================================================
    // Storage shape
    localparam int unsigned DATA_W = 9;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned DEPTH  = 64;
    localparam int unsigned PTR_W  = ADDR_W + 1;
    localparam int unsigned OFF_W  = 8;

    localparam logic [OFF_W-1:0] OFF_DEFAULT = 8'h07;
    localparam logic [PTR_W:0]   DEPTH_W     = 8'h40;

    // ========================================================
    // Register map, byte addresses
    localparam int unsigned AXI_AW = 4;
    localparam logic [AXI_AW-1:0] STATUS_OFS = 4'h0;
    localparam logic [AXI_AW-1:0] EMPTY_OFS  = 4'h4;
    localparam logic [AXI_AW-1:0] FULL_OFS   = 4'h8;

    localparam int unsigned ST_FULL_BIT   = 0;
    localparam int unsigned ST_AFULL_BIT  = 1;
    localparam int unsigned ST_EMPTY_BIT  = 2;
    localparam int unsigned ST_AEMPTY_BIT = 3;
    localparam int unsigned ST_DUAL_BIT   = 4;
    localparam int unsigned ST_COUNT_LSB  = 8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================================
    // Pin synchroniser bit positions
    localparam int unsigned PIN_WCLK  = 0;
    localparam int unsigned PIN_RCLK  = 1;
    localparam int unsigned PIN_CLR   = 2;
    localparam int unsigned PIN_WENA  = 3;
    localparam int unsigned PIN_WEN2  = 4;
    localparam int unsigned PIN_RENA  = 5;
    localparam int unsigned PIN_RENB  = 6;
    localparam int unsigned PIN_OE    = 7;
    localparam int unsigned PIN_DATA  = 8;
    localparam int unsigned PIN_W     = PIN_DATA + DATA_W;

    localparam logic [PIN_W-1:0] PIN_RESET = 17'h0_0004;

endpackage

// ===== dv/fifo_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_core_monitor
    import fifo_core_pkg::*;
(
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              write_clock,
    input wire logic              read_clock,
    input wire logic              clear_bar,
    input wire logic              read_enable_a_bar,
    input wire logic              read_enable_b_bar,
    input wire logic              output_enable_bar,
    input wire logic [DATA_W-1:0] data_out_bus,
    input wire logic              data_out_drive_bar,
    input wire logic              full_bar,
    input wire logic              almost_full_bar,
    input wire logic              empty_bar,
    input wire logic              almost_empty_bar
);
    // ==========
    // Helpers
    logic [3:0] calm_q;
    logic [5:0] wr_hist_q;
    logic [5:0] rd_hist_q;

    // Flags move on any reset, so edge checks wait until things settle
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !clear_bar)
            calm_q <= 4'h0;
        else if (!calm_q[3])
            calm_q <= calm_q + 4'h1;
    end

    always_ff @(posedge aclk)
    begin
        wr_hist_q <= {wr_hist_q[4:0], write_clock};
        rd_hist_q <= {rd_hist_q[4:0], read_clock};
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence clear_held;
        !clear_bar [*4];
    endsequence

    // ==========
    // Properties
    a_clear_sets_flags: assert property (
        clear_held |=> full_bar && almost_full_bar && !empty_bar
            && !almost_empty_bar && data_out_bus == '0)
        else $error("clear did not set flags and output");
    a_full_on_wclk: assert property (
        $changed({full_bar, almost_full_bar}) && calm_q[3] |-> |wr_hist_q)
        else $error("full flags moved without a write clock");
    a_empty_on_rclk: assert property (
        $changed({empty_bar, almost_empty_bar}) && calm_q[3] |-> |rd_hist_q)
        else $error("empty flags moved without a read clock");
    a_data_needs_read: assert property (
        $changed(data_out_bus) && calm_q[3] |-> |rd_hist_q
            && !read_enable_a_bar && !read_enable_b_bar)
        else $error("output changed without an enabled read");
    a_empty_holds_data: assert property (
        !empty_bar && calm_q[3] |=> $stable(data_out_bus))
        else $error("output changed while empty");
    a_full_has_afull: assert property (
        !full_bar |-> !almost_full_bar)
        else $error("full without almost full");
    a_empty_has_aempty: assert property (
        !empty_bar |-> !almost_empty_bar)
        else $error("empty without almost empty");
    a_oe_floats: assert property (
        output_enable_bar [*4] |-> data_out_drive_bar)
        else $error("outputs driven while disabled");
endmodule

bind fifo_core fifo_core_monitor u_fifo_core_monitor (
    .aclk(aclk), .aresetn(aresetn), .write_clock(write_clock),
    .read_clock(read_clock), .clear_bar(clear_bar),
    .read_enable_a_bar(read_enable_a_bar),
    .read_enable_b_bar(read_enable_b_bar),
    .output_enable_bar(output_enable_bar), .data_out_bus(data_out_bus),
    .data_out_drive_bar(data_out_drive_bar), .full_bar(full_bar),
    .almost_full_bar(almost_full_bar), .empty_bar(empty_bar),
    .almost_empty_bar(almost_empty_bar)
);
`default_nettype wire

// ===== dv/fifo_pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_pin_partner
    import fifo_core_pkg::*;
(
    input  wire logic         aclk,
    output logic              write_clock,
    output logic              read_clock,
    output logic              write_enable_a_bar,
    output logic              second_enable_or_load,
    output logic              read_enable_a_bar,
    output logic              read_enable_b_bar,
    output logic [DATA_W-1:0] data_in_bus
);
    // Pin clocks run only inside a frame; four aclk per phase so the
    // core's two-flop sampling never misses an edge
    initial
    begin
        write_clock = 1'b0;
        read_clock = 1'b0;
        write_enable_a_bar = 1'b1;
        second_enable_or_load = 1'b0;
        read_enable_a_bar = 1'b1;
        read_enable_b_bar = 1'b1;
        data_in_bus = 9'h000;
    end

    task automatic strap(input logic lvl);
        second_enable_or_load <= lvl;
    endtask

    task automatic push(input logic [DATA_W-1:0] d, input logic wa,
                        input logic w2);
        @(posedge aclk);
        data_in_bus <= d;
        write_enable_a_bar <= wa;
        second_enable_or_load <= w2;
        repeat (4) @(posedge aclk);
        write_clock <= 1'b1;
        repeat (4) @(posedge aclk);
        write_clock <= 1'b0;
        repeat (4) @(posedge aclk);
        write_enable_a_bar <= 1'b1;
        // Released data must not look like a held word
        data_in_bus <= ~d;
    endtask

    task automatic pop(input logic ra, input logic rb);
        @(posedge aclk);
        read_enable_a_bar <= ra;
        read_enable_b_bar <= rb;
        repeat (4) @(posedge aclk);
        read_clock <= 1'b1;
        repeat (4) @(posedge aclk);
        read_clock <= 1'b0;
        repeat (4) @(posedge aclk);
        read_enable_a_bar <= 1'b1;
        read_enable_b_bar <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import fifo_core_pkg::*;

    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic              clear_bar = 1'b0;
    logic              output_enable_bar = 1'b0;
    logic [AXI_AW-1:0] s_axi_awaddr = '0;
    logic [AXI_AW-1:0] s_axi_araddr = '0;
    logic [31:0]       s_axi_wdata = '0;
    logic [3:0]        s_axi_wstrb = 4'hf;
    logic              s_axi_awvalid = 1'b0;
    logic              s_axi_wvalid = 1'b0;
    logic              s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0;
    logic              s_axi_rready = 1'b0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic              s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
    logic [31:0]       s_axi_rdata;
    logic [DATA_W-1:0] data_out_bus;
    logic              data_out_drive_bar, full_bar, almost_full_bar;
    logic              empty_bar, almost_empty_bar;
    wire logic         write_clock, read_clock, write_enable_a_bar;
    wire logic         second_enable_or_load, read_enable_a_bar;
    wire logic         read_enable_b_bar;
    wire logic [DATA_W-1:0] data_in_bus;
    int                fail_count = 0;
    int                num_checks = 0;

    always #10 aclk = ~aclk;

    fifo_core u_fifo_core (.*);
    fifo_pin_partner u_fifo_pin_partner (.*);

    // ==========
    // Tasks
    function automatic logic [DATA_W-1:0] word(input int i);
        return DATA_W'(i * 37 + 9'h100);
    endfunction

    task automatic check_val(input string what, input logic [31:0] exp,
                             input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_flags(input logic [3:0] exp);
        check_val("flags", 32'(exp), 32'({full_bar, almost_full_bar,
                  empty_bar, almost_empty_bar}));
    endtask

    task automatic axi_write(input logic [AXI_AW-1:0] a,
                             input logic [31:0] d);
        logic aw_hit;
        logic w_hit;
        logic b_hit = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_hit)
        begin
            @(negedge aclk);
            aw_hit = s_axi_awvalid && s_axi_awready;
            w_hit = s_axi_wvalid && s_axi_wready;
            b_hit = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw_hit) s_axi_awvalid <= 1'b0;
            if (w_hit) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic reg_expect(input logic [AXI_AW-1:0] a,
                              input logic [31:0] exp, input logic [1:0] er);
        logic ar_hit;
        logic r_hit = 1'b0;
        logic [31:0] d;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_hit)
        begin
            @(negedge aclk);
            ar_hit = s_axi_arvalid && s_axi_arready;
            r_hit = s_axi_rvalid;
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar_hit) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        check_val("rdata", exp, d);
        check_val("rresp", 32'(er), 32'(resp));
    endtask

    task automatic clear_core(input logic lvl);
        @(posedge aclk);
        u_fifo_pin_partner.strap(lvl);
        clear_bar <= 1'b0;
        repeat (6) @(posedge aclk);
        clear_bar <= 1'b1;
        repeat (4) @(posedge aclk);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ==========
    // Sequence
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        clear_bar <= 1'b1;
        repeat (4) @(posedge aclk);
        check_flags(4'b1100);
        check_val("dout", 32'h0000_0000, 32'(data_out_bus));
        check_val("drive", 32'h0000_0000, 32'(data_out_drive_bar));
        reg_expect(STATUS_OFS, 32'h0000_0003, RESP_OKAY);
        reg_expect(EMPTY_OFS, 32'h0000_0007, RESP_OKAY);
        reg_expect(FULL_OFS, 32'h0000_0007, RESP_OKAY);
        reg_expect(4'hc, 32'h0000_0000, RESP_SLVERR);
        axi_write(4'hc, 32'h0000_00ff);
        check_val("bresp", 32'(RESP_SLVERR), 32'(resp));
        for (int i = 0; i < DEPTH; i++)
        begin
            u_fifo_pin_partner.push(word(i), 1'b0, 1'b0);
            check_val("afull", 32'(DEPTH - i - 1 > 7), 32'(almost_full_bar));
            check_val("full", 32'(i < DEPTH - 1), 32'(full_bar));
        end
        u_fifo_pin_partner.push(9'h0aa, 1'b0, 1'b0);
        reg_expect(STATUS_OFS, 32'h0000_4000, RESP_OKAY);
        u_fifo_pin_partner.pop(1'b0, 1'b0);
        check_val("dout", 32'h0000_0000, 32'(data_out_bus));
        check_flags(4'b0011);
        u_fifo_pin_partner.pop(1'b1, 1'b0);
        u_fifo_pin_partner.pop(1'b0, 1'b1);
        check_val("dout", 32'h0000_0000, 32'(data_out_bus));
        for (int i = 0; i < DEPTH; i++)
        begin
            u_fifo_pin_partner.pop(1'b0, 1'b0);
            check_val("dout", 32'(word(i)), 32'(data_out_bus));
            check_val("aempty", 32'(DEPTH - i - 1 > 7), 32'(almost_empty_bar));
            check_val("empty", 32'(i < DEPTH - 1), 32'(empty_bar));
            if (i == 0)
            begin
                check_val("full", 32'h0000_0000, 32'(full_bar));
                u_fifo_pin_partner.push(9'h0aa, 1'b1, 1'b0);
                check_val("full", 32'h0000_0001, 32'(full_bar));
            end
        end
        u_fifo_pin_partner.pop(1'b0, 1'b0);
        check_val("dout", 32'(word(63)), 32'(data_out_bus));
        clear_core(1'b1);
        check_flags(4'b1100);
        check_val("dout", 32'h0000_0000, 32'(data_out_bus));
        reg_expect(STATUS_OFS, 32'h0000_0013, RESP_OKAY);
        axi_write(EMPTY_OFS, 32'h0000_0000);
        u_fifo_pin_partner.push(9'h155, 1'b0, 1'b0);
        u_fifo_pin_partner.push(9'h0cc, 1'b0, 1'b1);
        u_fifo_pin_partner.pop(1'b1, 1'b1);
        check_flags(4'b1111);
        u_fifo_pin_partner.pop(1'b0, 1'b0);
        check_val("dout", 32'h0000_00cc, 32'(data_out_bus));
        u_fifo_pin_partner.push(9'h0dd, 1'b0, 1'b1);
        clear_core(1'b0);
        u_fifo_pin_partner.push(9'h033, 1'b0, 1'b0);
        u_fifo_pin_partner.pop(1'b1, 1'b1);
        check_flags(4'b1110);
        u_fifo_pin_partner.pop(1'b0, 1'b0);
        check_val("dout", 32'h0000_0033, 32'(data_out_bus));
        output_enable_bar <= 1'b1;
        repeat (4) @(posedge aclk);
        check_val("drive", 32'h0000_0001, 32'(data_out_drive_bar));
        complete_run();
    end

    // Whole run needs about 1900 cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire
